// ==== src/mb_pkg.sv ====
// Purpose: Shared constants for the memory buffer shift and cycle block
// Assumes: Bit position n of the word sits at index n-1
// Notes: Addresses are 12 bits wide, matching four octal digits
package mb_pkg;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 12;
	// ------------------------------------------------------------
	// Special write addresses
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_CYCLE_RIGHT = 12'h010;
	localparam logic [11:0] ADDR_SHIFT_RIGHT = 12'h011;
	localparam logic [11:0] ADDR_CYCLE_LEFT = 12'h012;
	localparam logic [11:0] ADDR_SHIFT_LEFT = 12'h013;
	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int PARITY_IDX = 14;
	localparam int TOP_IDX = 15;
	localparam int LOW_TOP_IDX = 13;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [15:0] PARITY_MASK = 16'h4000;
endpackage

// ==== src/mb_bit_slice.sv ====
// Purpose: One bit slice of three write gates
// Assumes: Strobes are active high and one cycle wide
// Notes: Pure combinational gating
`timescale 1ns/1ns
`default_nettype none
module mb_bit_slice (
	// Write line bit
	input wire logic write_line_bit,
	// Gate strobes
	input wire logic straight_en,
	input wire logic right_en,
	input wire logic left_en,
	// Gated outputs
	output logic slice_straight_out,
	output logic slice_right_out,
	output logic slice_left_out
);
	assign slice_straight_out = write_line_bit & straight_en;
	assign slice_right_out = write_line_bit & right_en;
	assign slice_left_out = write_line_bit & left_en;
endmodule
`default_nettype wire

// ==== src/mb_strobe_decode.sv ====
// Purpose: Decodes special addresses into the six write strobes
// Assumes: Address and pulses come from logic on the same clock
// Notes: Combinational; strobes exist only inside the write phase
`timescale 1ns/1ns
`default_nettype none
module mb_strobe_decode (
	// Address and write pulse
	input wire logic [11:0] address,
	input wire logic buffer_write_pulse,
	input wire logic phase_234,
	// Strobes
	output logic straight_write_strobe,
	output logic right_move_strobe,
	output logic left_move_strobe,
	output logic wrap_to_top_strobe,
	output logic sign_copy_strobe,
	output logic wrap_to_bottom_strobe
);
	logic write_go;
	logic special;
	assign write_go = buffer_write_pulse & phase_234;
	assign special = (address[11:2] == mb_pkg::ADDR_CYCLE_RIGHT[11:2]);
	assign straight_write_strobe = write_go & ~special;
	assign sign_copy_strobe = write_go & (~special | address == mb_pkg::ADDR_SHIFT_RIGHT
		| address == mb_pkg::ADDR_SHIFT_LEFT);
	assign right_move_strobe = write_go & special & ~address[1];
	assign left_move_strobe = write_go & special & address[1];
	assign wrap_to_top_strobe = write_go & (address == mb_pkg::ADDR_CYCLE_RIGHT);
	assign wrap_to_bottom_strobe = write_go & (address == mb_pkg::ADDR_CYCLE_LEFT);
endmodule
`default_nettype wire

// ==== src/mb_shift_top.sv ====
// Purpose: Memory buffer register with shift and cycle write gating
// Assumes: Phase and control inputs are same-clock levels from the sequencer
// Notes: Writes set bits on top of the cleared or held contents
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module mb_shift_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Write side
	input wire logic [15:0] write_line_bits,
	input wire logic [11:0] address,
	input wire logic buffer_write_pulse,
	input wire logic parity_bit_in,
	// Timing phases
	input wire logic phase_12,
	input wire logic phase_234,
	input wire logic time_six,
	// Sequencer control pulses
	input wire logic buffer_clear_pulse,
	input wire logic read_control_pulse,
	input wire logic generate_parity_pulse,
	input wire logic parity_latch_readout,
	input wire logic counter_increment,
	input wire logic counter_decrement,
	input wire logic counter_shift,
	// Strobes and controls
	output logic straight_write_strobe,
	output logic right_move_strobe,
	output logic left_move_strobe,
	output logic wrap_to_top_strobe,
	output logic sign_copy_strobe,
	output logic wrap_to_bottom_strobe,
	output logic buffer_clear,
	output logic parity_position_clear,
	output logic buffer_read_signal,
	// Data
	output logic [15:0] buffer_word,
	output logic [15:0] read_data
);
	// ------------------------------------------------------------
	// Strobe decode
	// ------------------------------------------------------------
	mb_strobe_decode u_decode (
		.address(address),
		.buffer_write_pulse(buffer_write_pulse),
		.phase_234(phase_234),
		.straight_write_strobe(straight_write_strobe),
		.right_move_strobe(right_move_strobe),
		.left_move_strobe(left_move_strobe),
		.wrap_to_top_strobe(wrap_to_top_strobe),
		.sign_copy_strobe(sign_copy_strobe),
		.wrap_to_bottom_strobe(wrap_to_bottom_strobe)
	);

	// ------------------------------------------------------------
	// Bit slices
	// ------------------------------------------------------------
	logic [15:0] slice_straight_out;
	logic [15:0] slice_right_out;
	logic [15:0] slice_left_out;
	logic [15:0] slice_in;
	logic [15:0] straight_en;
	logic [15:0] right_en;
	logic [15:0] left_en;

	always_comb begin
		for (int k = 0; k < 16; k++) begin
			slice_in[k] = write_line_bits[k];
			straight_en[k] = straight_write_strobe;
			right_en[k] = right_move_strobe;
			left_en[k] = left_move_strobe;
		end
		// Top slice straight gate follows the sign copy strobe
		straight_en[mb_pkg::TOP_IDX] = sign_copy_strobe;
		// Bit one only wraps on cycle right
		right_en[0] = wrap_to_top_strobe;
		// Bit fourteen only wraps on cycle left
		left_en[mb_pkg::LOW_TOP_IDX] = wrap_to_bottom_strobe;
		// Parity slice takes the parity bit and never moves
		slice_in[mb_pkg::PARITY_IDX] = parity_bit_in;
		right_en[mb_pkg::PARITY_IDX] = 1'b0;
		left_en[mb_pkg::PARITY_IDX] = 1'b0;
	end

	for (genvar k = 0; k < 16; k++) begin : g_slice
		mb_bit_slice u_slice (
			.write_line_bit(slice_in[k]),
			.straight_en(straight_en[k]),
			.right_en(right_en[k]),
			.left_en(left_en[k]),
			.slice_straight_out(slice_straight_out[k]),
			.slice_right_out(slice_right_out[k]),
			.slice_left_out(slice_left_out[k])
		);
	end

	// ------------------------------------------------------------
	// Routing of slice outputs to register positions
	// ------------------------------------------------------------
	logic [15:0] gated;

	always_comb begin
		gated = slice_straight_out;
		for (int k = 1; k < 14; k++) begin
			gated[k - 1] = gated[k - 1] | slice_right_out[k];
		end
		gated[mb_pkg::TOP_IDX] = gated[mb_pkg::TOP_IDX] | slice_right_out[0];
		gated[mb_pkg::LOW_TOP_IDX] = gated[mb_pkg::LOW_TOP_IDX] | slice_right_out[mb_pkg::TOP_IDX];
		for (int k = 0; k < 13; k++) begin
			gated[k + 1] = gated[k + 1] | slice_left_out[k];
		end
		gated[mb_pkg::TOP_IDX] = gated[mb_pkg::TOP_IDX] | slice_left_out[mb_pkg::LOW_TOP_IDX];
		gated[0] = gated[0] | slice_left_out[mb_pkg::TOP_IDX];
	end

	// ------------------------------------------------------------
	// Clear and read controls
	// ------------------------------------------------------------
	logic counter_op_flag;
	assign counter_op_flag = counter_increment | counter_decrement | counter_shift;
	assign buffer_clear = (buffer_write_pulse & phase_12) | buffer_clear_pulse;
	assign parity_position_clear = (generate_parity_pulse & phase_12) | buffer_clear_pulse
		| parity_latch_readout;
	assign buffer_read_signal = (read_control_pulse & phase_234) | (time_six & counter_op_flag);

	// ------------------------------------------------------------
	// Buffer register
	// ------------------------------------------------------------
	logic [15:0] word_r;
	logic [15:0] word_nxt;
	logic [15:0] read_r;
	logic [15:0] read_nxt;

	always_comb begin
		word_nxt = word_r;
		if (buffer_clear) begin
			word_nxt = mb_pkg::WORD_RESET;
		end
		if (parity_position_clear) begin
			word_nxt = word_nxt & ~mb_pkg::PARITY_MASK;
		end
		// Set after clear, so a same-cycle write survives
		word_nxt = word_nxt | gated;
		read_nxt = buffer_read_signal ? word_r : mb_pkg::WORD_RESET;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			word_r <= mb_pkg::WORD_RESET;
			read_r <= mb_pkg::WORD_RESET;
		end else begin
			word_r <= word_nxt;
			read_r <= read_nxt;
		end
	end

	assign buffer_word = word_r;
	assign read_data = read_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	function automatic logic [15:0] base_of(input logic [15:0] w, input logic clr, input logic pclr);
		logic [15:0] b;
		b = clr ? mb_pkg::WORD_RESET : w;
		if (pclr) begin
			b = b & ~mb_pkg::PARITY_MASK;
		end
		return b;
	endfunction

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic special_write;
	assign special_write = buffer_write_pulse & phase_234 & (address[11:2] == mb_pkg::ADDR_CYCLE_RIGHT[11:2]);

	a_cycle_right_word: assert property (
		(special_write && address == mb_pkg::ADDR_CYCLE_RIGHT) |=> word_r ==
		(base_of($past(word_r), $past(buffer_clear), $past(parity_position_clear))
		| {$past(write_line_bits[0]), 1'b0, $past(write_line_bits[15]), $past(write_line_bits[13:1])}))
		else $error("cycle right word wrong");
	a_shift_right_word: assert property (
		(special_write && address == mb_pkg::ADDR_SHIFT_RIGHT) |=> word_r ==
		(base_of($past(word_r), $past(buffer_clear), $past(parity_position_clear))
		| {$past(write_line_bits[15]), 1'b0, $past(write_line_bits[15]), $past(write_line_bits[13:1])}))
		else $error("shift right word wrong");
	a_cycle_left_word: assert property (
		(special_write && address == mb_pkg::ADDR_CYCLE_LEFT) |=> word_r ==
		(base_of($past(word_r), $past(buffer_clear), $past(parity_position_clear))
		| {$past(write_line_bits[13]), 1'b0, $past(write_line_bits[12:0]), $past(write_line_bits[15])}))
		else $error("cycle left word wrong");
	a_shift_left_word: assert property (
		(special_write && address == mb_pkg::ADDR_SHIFT_LEFT) |=> word_r ==
		(base_of($past(word_r), $past(buffer_clear), $past(parity_position_clear))
		| {$past(write_line_bits[15]), 1'b0, $past(write_line_bits[12:0]), $past(write_line_bits[15])}))
		else $error("shift left word wrong");
	a_straight_write_word: assert property (
		straight_write_strobe |=> word_r ==
		(base_of($past(word_r), $past(buffer_clear), $past(parity_position_clear))
		| {$past(write_line_bits[15]), $past(parity_bit_in), $past(write_line_bits[13:0])}))
		else $error("straight write word wrong");
	a_special_no_straight: assert property (
		special_write |-> !straight_write_strobe && (right_move_strobe ^ left_move_strobe))
		else $error("special write kept straight strobe");
	a_move_needs_write: assert property (
		(right_move_strobe || left_move_strobe) |-> buffer_write_pulse && phase_234)
		else $error("move strobe without write pulse");
	a_clear_word_zero: assert property (
		(buffer_clear && !buffer_write_pulse) |=> word_r == mb_pkg::WORD_RESET)
		else $error("buffer clear did not empty word");
	a_parity_clear_bit: assert property (
		(parity_position_clear && !straight_write_strobe) |=> !word_r[mb_pkg::PARITY_IDX])
		else $error("parity position not cleared");
	a_parity_kept_moves: assert property (
		(special_write && !buffer_clear && !parity_position_clear)
		|=> word_r[mb_pkg::PARITY_IDX] == $past(word_r[mb_pkg::PARITY_IDX]))
		else $error("move disturbed parity position");
	a_read_data_word: assert property (
		(phase_234 && read_control_pulse) || (time_six && counter_op_flag)
		|=> read_data == $past(word_r))
		else $error("read data not the buffer word");
	a_read_idle_zero: assert property (
		!buffer_read_signal |=> read_data == mb_pkg::WORD_RESET)
		else $error("read data without read signal");
	a_write_same_cycle: assert property (
		(buffer_clear && straight_write_strobe) |=> word_r[12:0] == $past(write_line_bits[12:0]))
		else $error("write lost against clear");

	// ------------------------------------------------------------
	// Decode, control and routing checks
	// ------------------------------------------------------------
	a_wrap_top_decode: assert property (
		wrap_to_top_strobe |-> right_move_strobe && !sign_copy_strobe && address == mb_pkg::ADDR_CYCLE_RIGHT)
		else $error("wrap to top outside cycle right");
	a_shift_right_decode: assert property (
		(special_write && address == mb_pkg::ADDR_SHIFT_RIGHT) |-> right_move_strobe && sign_copy_strobe
		&& !wrap_to_top_strobe)
		else $error("shift right strobes wrong");
	a_wrap_bottom_decode: assert property (
		wrap_to_bottom_strobe |-> left_move_strobe && !sign_copy_strobe && address == mb_pkg::ADDR_CYCLE_LEFT)
		else $error("wrap to bottom outside cycle left");
	a_shift_left_decode: assert property (
		(special_write && address == mb_pkg::ADDR_SHIFT_LEFT) |-> left_move_strobe && sign_copy_strobe
		&& !wrap_to_bottom_strobe)
		else $error("shift left strobes wrong");
	a_plain_write_decode: assert property (
		(buffer_write_pulse && phase_234 && !special_write) |-> straight_write_strobe && sign_copy_strobe
		&& !right_move_strobe && !left_move_strobe)
		else $error("plain write strobes wrong");
	a_right_feeds_lower: assert property (
		(right_move_strobe && !buffer_clear && !parity_position_clear)
		|=> (word_r[12:0] & $past(write_line_bits[13:1])) == $past(write_line_bits[13:1]))
		else $error("right move lost a bit");
	a_left_feeds_higher: assert property (
		(left_move_strobe && !buffer_clear && !parity_position_clear)
		|=> (word_r[13:1] & $past(write_line_bits[12:0])) == $past(write_line_bits[12:0]))
		else $error("left move lost a bit");
	a_clear_sources: assert property (
		((buffer_write_pulse && phase_12) || buffer_clear_pulse) |-> buffer_clear)
		else $error("buffer clear missing");
	a_clear_needs_source: assert property (
		buffer_clear |-> (buffer_write_pulse && phase_12) || buffer_clear_pulse)
		else $error("buffer clear without source");
	a_read_sources: assert property (
		((read_control_pulse && phase_234) || (time_six && (counter_increment || counter_decrement
		|| counter_shift))) |-> buffer_read_signal)
		else $error("buffer read signal missing");
	a_read_needs_source: assert property (
		buffer_read_signal |-> (read_control_pulse && phase_234) || time_six)
		else $error("buffer read signal without source");
	a_parity_clear_sources: assert property (
		((generate_parity_pulse && phase_12) || buffer_clear_pulse || parity_latch_readout)
		|-> parity_position_clear)
		else $error("parity position clear missing");
	a_parity_write_wins: assert property (
		(straight_write_strobe && parity_position_clear) |=> word_r[mb_pkg::PARITY_IDX] == $past(parity_bit_in))
		else $error("parity bit lost against its clear");
	a_move_needs_special: assert property (
		(right_move_strobe || left_move_strobe || wrap_to_top_strobe || wrap_to_bottom_strobe) |-> special_write)
		else $error("move strobe on plain address");
	a_parity_slice_still: assert property (
		special_write |-> !slice_right_out[mb_pkg::PARITY_IDX] && !slice_left_out[mb_pkg::PARITY_IDX])
		else $error("parity slice moved");
	a_word_holds_idle: assert property (
		(!buffer_clear && !parity_position_clear && !buffer_write_pulse) |=> word_r == $past(word_r))
		else $error("word changed without write or clear");
	a_clear_then_move: assert property (
		(buffer_clear && special_write) |=> !word_r[mb_pkg::PARITY_IDX])
		else $error("move after clear kept parity bit");
endmodule
`default_nettype wire

// ==== sim/mb_sequencer_model.sv ====
// Purpose: Behavioural sequencer and write bus that drive the buffer block
// Assumes: One call of issue covers one machine cycle
// Notes: Every control changes by non-blocking assignment just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module mb_sequencer_model (
	// Clock
	input wire logic sys_clk,
	// Write side
	output logic [15:0] write_line_bits,
	output logic [11:0] address,
	output logic buffer_write_pulse,
	output logic parity_bit_in,
	// Timing phases
	output logic phase_12,
	output logic phase_234,
	output logic time_six,
	// Control pulses
	output logic buffer_clear_pulse,
	output logic read_control_pulse,
	output logic generate_parity_pulse,
	output logic parity_latch_readout,
	output logic counter_increment,
	output logic counter_decrement,
	output logic counter_shift
);
	initial begin
		write_line_bits = 16'h0000;
		address = 12'h000;
		{parity_bit_in, buffer_write_pulse, phase_12, phase_234, time_six, buffer_clear_pulse} = 6'h00;
		{read_control_pulse, generate_parity_pulse, parity_latch_readout} = 3'h0;
		{counter_increment, counter_decrement, counter_shift} = 3'h0;
	end

	// One address and at most one write pulse per cycle
	task automatic issue(input logic [11:0] a, input logic [15:0] w, input logic [11:0] c);
		@(posedge sys_clk);
		address <= a;
		write_line_bits <= w;
		{parity_bit_in, buffer_write_pulse, phase_12, phase_234, time_six, buffer_clear_pulse,
			read_control_pulse, generate_parity_pulse, parity_latch_readout, counter_increment,
			counter_decrement, counter_shift} <= c;
	endtask
endmodule
`default_nettype wire

// ==== sim/memory_buffer_shift_cycle_tb.sv ====
// Purpose: Self-checking bench for the buffer shift and cycle block
// Assumes: Reference model below sees the same inputs as the design
// Notes: All outputs compared on every falling edge
`timescale 1ns/1ns
`default_nettype none
module memory_buffer_shift_cycle_tb;
	localparam logic [11:0] C_PAR = 12'h800, C_WP = 12'h400, C_P12 = 12'h200, C_P234 = 12'h100;
	localparam logic [11:0] C_T6 = 12'h080, C_CLR = 12'h040, C_RCP = 12'h020, C_GP = 12'h010;
	localparam logic [11:0] C_PLR = 12'h008, C_INC = 12'h004, C_DEC = 12'h002, C_SHF = 12'h001;
	localparam logic [11:0] CTAB [12] = '{C_GP | C_P12, C_PLR, C_GP, C_P12 | C_WP, C_CLR, C_RCP | C_P234,
		C_RCP, C_T6 | C_INC, C_T6 | C_DEC, C_T6 | C_SHF, C_T6, C_INC | C_DEC | C_SHF};
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] write_line_bits, buffer_word, read_data, exp_word, exp_rd, nxt;
	logic [11:0] address;
	logic buffer_write_pulse, parity_bit_in, phase_12, phase_234, time_six, buffer_clear_pulse;
	logic read_control_pulse, generate_parity_pulse, parity_latch_readout;
	logic counter_increment, counter_decrement, counter_shift;
	logic straight_write_strobe, right_move_strobe, left_move_strobe, wrap_to_top_strobe;
	logic sign_copy_strobe, wrap_to_bottom_strobe, buffer_clear, parity_position_clear, buffer_read_signal;
	logic we, sp, clr_exp, pclr_exp, rd_exp;
	logic [31:0] r1, r2;
	logic [15:0] strb_seen, strb_exp, ctl_seen, ctl_exp;
	int err_total = 0;
	int samples_checked = 0;
	int seed = 32'hECAE;

	always #20 sys_clk = ~sys_clk;

	mb_sequencer_model mb_sequencer_model_i (.sys_clk(sys_clk), .write_line_bits(write_line_bits),
		.address(address), .buffer_write_pulse(buffer_write_pulse), .parity_bit_in(parity_bit_in),
		.phase_12(phase_12), .phase_234(phase_234), .time_six(time_six), .buffer_clear_pulse(buffer_clear_pulse),
		.read_control_pulse(read_control_pulse), .generate_parity_pulse(generate_parity_pulse),
		.parity_latch_readout(parity_latch_readout), .counter_increment(counter_increment),
		.counter_decrement(counter_decrement), .counter_shift(counter_shift));

	mb_shift_top mb_shift_top_i (.sys_clk(sys_clk), .rst(rst), .write_line_bits(write_line_bits),
		.address(address), .buffer_write_pulse(buffer_write_pulse), .parity_bit_in(parity_bit_in),
		.phase_12(phase_12), .phase_234(phase_234), .time_six(time_six), .buffer_clear_pulse(buffer_clear_pulse),
		.read_control_pulse(read_control_pulse), .generate_parity_pulse(generate_parity_pulse),
		.parity_latch_readout(parity_latch_readout), .counter_increment(counter_increment),
		.counter_decrement(counter_decrement), .counter_shift(counter_shift),
		.straight_write_strobe(straight_write_strobe), .right_move_strobe(right_move_strobe),
		.left_move_strobe(left_move_strobe), .wrap_to_top_strobe(wrap_to_top_strobe),
		.sign_copy_strobe(sign_copy_strobe), .wrap_to_bottom_strobe(wrap_to_bottom_strobe),
		.buffer_clear(buffer_clear), .parity_position_clear(parity_position_clear),
		.buffer_read_signal(buffer_read_signal), .buffer_word(buffer_word), .read_data(read_data));

	// ------------------------------------------------------------
	// Reference model
	// ------------------------------------------------------------
	assign we = buffer_write_pulse & phase_234;
	assign sp = (address >= mb_pkg::ADDR_CYCLE_RIGHT) && (address <= mb_pkg::ADDR_SHIFT_LEFT);
	assign clr_exp = (buffer_write_pulse & phase_12) | buffer_clear_pulse;
	assign pclr_exp = (generate_parity_pulse & phase_12) | buffer_clear_pulse | parity_latch_readout;
	assign rd_exp = (read_control_pulse & phase_234) | (time_six & (counter_increment | counter_decrement | counter_shift));
	assign strb_seen = {10'h000, straight_write_strobe, right_move_strobe, left_move_strobe, wrap_to_top_strobe,
		sign_copy_strobe, wrap_to_bottom_strobe};
	assign strb_exp = {10'h000, we & ~sp, we & sp & ~address[1], we & sp & address[1],
		we & sp & (address[1:0] == 2'h0), we & (~sp | address[0]), we & sp & (address[1:0] == 2'h2)};
	assign ctl_seen = {13'h0, buffer_clear, parity_position_clear, buffer_read_signal};
	assign ctl_exp = {13'h0, clr_exp, pclr_exp, rd_exp};

	function automatic logic [15:0] pattern(input logic [11:0] a, input logic [15:0] w, input logic par);
		logic [15:0] r;
		int m;
		r = 16'h0000;
		m = int'(a) - int'(mb_pkg::ADDR_CYCLE_RIGHT);
		if (m < 0 || m > 3) begin
			r = w;
			r[14] = par;
		end else if (m < 2) begin
			for (int k = 1; k <= 13; k++)
				r[k - 1] = w[k];
			r[13] = w[15];
			r[15] = (m == 0) ? w[0] : w[15];
		end else begin
			for (int k = 2; k <= 14; k++)
				r[k - 1] = w[k - 2];
			r[0] = w[15];
			r[15] = (m == 2) ? w[13] : w[15];
		end
		return r;
	endfunction

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			exp_word <= 16'h0000;
			exp_rd <= 16'h0000;
		end else begin
			nxt = exp_word;
			if (clr_exp)
				nxt = 16'h0000;
			if (pclr_exp)
				nxt[14] = 1'b0;
			if (we)
				nxt = nxt | pattern(address, write_line_bits, parity_bit_in);
			exp_word <= nxt;
			exp_rd <= rd_exp ? exp_word : 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// Comparison and closing
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	always @(negedge sys_clk) begin
		check("strobes", strb_seen, strb_exp);
		check("controls", ctl_seen, ctl_exp);
		check("word", buffer_word, exp_word);
		check("read", read_data, exp_rd);
	end

	task automatic close_out();
		$display("Checked %0d samples, %0d mismatches", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		#(40 * 3000);
		err_total++;
		close_out();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		// Parity preloaded, then move write (a plain write at 0x014 on the last pass), then clear and write together, then read
		for (int i = 0; i < 5; i++) begin
			mb_sequencer_model_i.issue(12'h000, 16'h0000, C_CLR);
			mb_sequencer_model_i.issue(12'h000, 16'h0000, C_PAR | C_WP | C_P234);
			mb_sequencer_model_i.issue(mb_pkg::ADDR_CYCLE_RIGHT + 12'(i), 16'hC5A3, C_WP | C_P234);
			mb_sequencer_model_i.issue(mb_pkg::ADDR_CYCLE_RIGHT + 12'(i), 16'h3A5C, C_WP | C_P12 | C_P234);
			mb_sequencer_model_i.issue(12'h000, 16'h0000, C_RCP | C_P234);
		end
		$display("Test shift and cycle done");
		for (int i = 0; i < 12; i++) begin
			mb_sequencer_model_i.issue(12'h000, 16'h7E81, C_PAR | C_WP | C_P234);
			mb_sequencer_model_i.issue(12'h000, 16'h0000, CTAB[i]);
			mb_sequencer_model_i.issue(12'h000, 16'h0000, 12'h000);
		end
		$display("Test clear and read done");
		repeat (400) begin
			r1 = $random(seed);
			r2 = $random(seed);
			mb_sequencer_model_i.issue(r1[3] ? r1[15:4] : {9'h002, r1[2:0]}, r2[15:0], r2[27:16]);
		end
		$display("Test random done");
		close_out();
	end
endmodule
`default_nettype wire
